// *** rtl/dtu_pkg.sv ***
// Shared constants and types for the dual timer and external interrupt unit
// Functional notes
// R1 - Timer 1 overflow sets its flag, which is cleared when its service routine is entered.
// R2 - Timer 0 overflow sets its flag, which is cleared when its service routine is entered.
// R3 - Timer 1 counts only with its run bit set, and also needs pin b high when gated.
// R4 - Timer 0 counts only with its run bit set, and also needs pin a high when gated.
// R5 - Every falling edge on pin b sets its edge flag, which is cleared on routine entry.
// R6 - Every falling edge on pin a sets its edge flag, which is cleared on routine entry.
// R7 - Interrupt b requests on a low level when its trigger select is 0, on a falling edge when 1.
// R8 - Interrupt a requests on a low level when its trigger select is 0, on a falling edge when 1.
// R9 - Timer 1 steps every second clock as a timer, or on falling edges of count input b.
// R10 - Timer 0 steps every second clock as a timer, or on falling edges of count input a.
// R11 - Timer 1 modes: 00 prescaled 8-bit, 01 full 16-bit, 11 halted.
// R12 - Timer 1 mode 10 reloads the low byte from the high byte on each low-byte overflow.
// R13 - Timer 0 modes: 00 prescaled 8-bit, 01 full 16-bit.
// R14 - Timer 0 mode 10 reloads the low byte from the high byte on each low-byte overflow.
// R15 - Timer 0 mode 11 splits into two 8-bit counters, the high one run and flagged by timer 1.
// R16 - An overflow is the counting register wrapping from all ones to zero.
package dtu_pkg;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h88;
  localparam logic [IDX_W-1:0] IDX_MODE = 8'h89;
  localparam logic [IDX_W-1:0] IDX_TL0 = 8'h8A;
  localparam logic [IDX_W-1:0] IDX_TL1 = 8'h8B;
  localparam logic [IDX_W-1:0] IDX_TH0 = 8'h8C;
  localparam logic [IDX_W-1:0] IDX_TH1 = 8'h8D;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'hA0;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 8'hA1;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 8'hA2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [1:0] MODE_PRESC = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [4:0] PRESC_MAX = 5'h1F;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  typedef struct packed {
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic ie1;
    logic it1;
    logic ie0;
    logic it0;
  } dtu_ctrl_s;
  typedef struct packed {
    logic t1_gate;
    logic t1_count;
    logic [1:0] t1_mode;
    logic t0_gate;
    logic t0_count;
    logic [1:0] t0_mode;
  } dtu_mode_s;
  // One bit per interrupt source, also the layout of the status registers
  typedef struct packed {
    logic ext1;
    logic tf1;
    logic ext0;
    logic tf0;
  } dtu_vec_s;
endpackage

// *** rtl/dtu_cnt.sv ***
// One timer's low and high data bytes with their mode-dependent counting
`timescale 1ns/1ps
`default_nettype none
module dtu_cnt
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Control
  input wire logic [1:0] i_mode,
  input wire logic i_inc,
  input wire logic i_inc_hi,
  // Software writes
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  // State and overflow pulses
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic o_ovf,
  output logic o_ovf_hi
);
  logic [7:0] next_lo;
  logic [7:0] next_hi;

  always_comb
  begin
    next_lo = o_lo;
    next_hi = o_hi;
    o_ovf = 1'b0;
    o_ovf_hi = 1'b0;
    if (i_inc)
    begin
      case (i_mode)
        // R13 R11 prescaler carry steps the high byte
        dtu_pkg::MODE_PRESC:
        begin
          if (o_lo[4:0] == dtu_pkg::PRESC_MAX)
          begin
            next_lo[4:0] = 5'h00;
            next_hi = 8'(o_hi + 8'h01);
            // R16 high byte wrap
            o_ovf = (o_hi == dtu_pkg::BYTE_MAX);
          end
          else
            next_lo[4:0] = 5'(o_lo[4:0] + 5'h01);
        end
        // R13 R11 full 16-bit count
        dtu_pkg::MODE_16:
        begin
          {next_hi, next_lo} = 16'({o_hi, o_lo} + 16'h0001);
          o_ovf = (o_hi == dtu_pkg::BYTE_MAX) && (o_lo == dtu_pkg::BYTE_MAX);
        end
        // R12 R14 reload low from high
        dtu_pkg::MODE_RELOAD:
        begin
          if (o_lo == dtu_pkg::BYTE_MAX)
          begin
            next_lo = o_hi;
            o_ovf = 1'b1;
          end
          else
            next_lo = 8'(o_lo + 8'h01);
        end
        default:
        begin
          // R15 low byte counts alone
          next_lo = 8'(o_lo + 8'h01);
          o_ovf = (o_lo == dtu_pkg::BYTE_MAX);
        end
      endcase
    end
    // R15 high byte as second counter
    if (i_inc_hi && i_mode == dtu_pkg::MODE_SPLIT)
    begin
      next_hi = 8'(o_hi + 8'h01);
      o_ovf_hi = (o_hi == dtu_pkg::BYTE_MAX);
    end
    if (i_wr_lo)
      next_lo = i_wdata;
    if (i_wr_hi)
      next_hi = i_wdata;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_lo <= dtu_pkg::RST_BYTE;
      o_hi <= dtu_pkg::RST_BYTE;
    end
    else
    begin
      o_lo <= next_lo;
      o_hi <= next_hi;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dtu_top.sv ***
// Dual timer/counter with external interrupts behind an Avalon-MM slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtu_top
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [dtu_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pins
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic i_count_input_a,
  input wire logic i_count_input_b,
  // Service routine entry, one pulse per source
  input wire dtu_pkg::dtu_vec_s i_isr_ack,
  // Interrupt requests
  output dtu_pkg::dtu_vec_s o_int_req,
  output logic o_irq
);
  dtu_pkg::dtu_ctrl_s ctrl;
  dtu_pkg::dtu_ctrl_s next_ctrl;
  dtu_pkg::dtu_mode_s mode;
  dtu_pkg::dtu_mode_s next_mode;
  dtu_pkg::dtu_vec_s stat;
  dtu_pkg::dtu_vec_s next_stat;
  dtu_pkg::dtu_vec_s irq_en;
  dtu_pkg::dtu_vec_s next_irq_en;
  dtu_pkg::dtu_vec_s next_int_req;
  dtu_pkg::dtu_vec_s events;
  logic next_irq;
  logic ack;
  logic [31:0] next_rdata;
  logic half;
  logic [3:0] pins_q;
  logic fall_irq_a;
  logic fall_irq_b;
  logic fall_cnt_a;
  logic fall_cnt_b;
  logic [dtu_pkg::IDX_W-1:0] idx;
  logic wr;
  logic rd;
  logic t0_inc;
  logic t0_inc_hi;
  logic t1_inc;
  logic [7:0] t0_lo;
  logic [7:0] t0_hi;
  logic [7:0] t1_lo;
  logic [7:0] t1_hi;
  logic t0_ovf;
  logic t0_ovf_hi;
  logic t1_ovf;

  function automatic logic hit(input logic [dtu_pkg::IDX_W-1:0] want);
    hit = wr && (idx == want) && i_avs_byteenable[0];
  endfunction

  // Bus: one wait cycle, then the access completes
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
  assign idx = i_avs_address[dtu_pkg::ADDR_W-1:2];
  assign wr = i_avs_write && ack && (i_avs_address[1:0] == 2'h0);
  // Read data loaded in the wait cycle, standing at the completing edge
  assign rd = i_avs_read && !ack;

  // Pin edge detection
  assign fall_irq_a = pins_q[0] && !i_ext_irq_pin_a;
  assign fall_irq_b = pins_q[1] && !i_ext_irq_pin_b;
  assign fall_cnt_a = pins_q[2] && !i_count_input_a;
  assign fall_cnt_b = pins_q[3] && !i_count_input_b;

  always_comb
  begin
    // R4 run and gate for timer 0
    t0_inc = ctrl.tr0 && (!mode.t0_gate || i_ext_irq_pin_a);
    // R10 clock half rate or count pin
    t0_inc = t0_inc && (mode.t0_count ? fall_cnt_a : half);
    // R3 run and gate for timer 1
    t1_inc = ctrl.tr1 && (!mode.t1_gate || i_ext_irq_pin_b);
    // R9 clock half rate or count pin
    t1_inc = t1_inc && (mode.t1_count ? fall_cnt_b : half);
    // R11 mode 11 halts timer 1
    if (mode.t1_mode == dtu_pkg::MODE_SPLIT)
      t1_inc = 1'b0;
    // R15 split high byte run by timer 1 bit
    t0_inc_hi = ctrl.tr1 && half;
  end

  dtu_cnt u_t0
  (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_mode(mode.t0_mode),
    .i_inc(t0_inc),
    .i_inc_hi(t0_inc_hi),
    .i_wr_lo(hit(dtu_pkg::IDX_TL0)),
    .i_wr_hi(hit(dtu_pkg::IDX_TH0)),
    .i_wdata(i_avs_writedata[7:0]),
    .o_lo(t0_lo),
    .o_hi(t0_hi),
    .o_ovf(t0_ovf),
    .o_ovf_hi(t0_ovf_hi)
  );

  dtu_cnt u_t1
  (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_mode(mode.t1_mode),
    .i_inc(t1_inc),
    .i_inc_hi(1'b0),
    .i_wr_lo(hit(dtu_pkg::IDX_TL1)),
    .i_wr_hi(hit(dtu_pkg::IDX_TH1)),
    .i_wdata(i_avs_writedata[7:0]),
    .o_lo(t1_lo),
    .o_hi(t1_hi),
    .o_ovf(t1_ovf),
    .o_ovf_hi()
  );

  always_comb
  begin
    next_ctrl = ctrl;
    if (hit(dtu_pkg::IDX_CTRL))
      next_ctrl = i_avs_writedata[7:0];
    // R2 R1 R6 R5 cleared on routine entry
    if (i_isr_ack.tf0)
      next_ctrl.tf0 = 1'b0;
    if (i_isr_ack.tf1)
      next_ctrl.tf1 = 1'b0;
    if (i_isr_ack.ext0)
      next_ctrl.ie0 = 1'b0;
    if (i_isr_ack.ext1)
      next_ctrl.ie1 = 1'b0;
    // R2 overflow sets flag, set wins
    if (t0_ovf)
      next_ctrl.tf0 = 1'b1;
    // R1 R15 timer 1 flag set
    if (t1_ovf || t0_ovf_hi)
      next_ctrl.tf1 = 1'b1;
    // R6 falling edge sets flag
    if (fall_irq_a)
      next_ctrl.ie0 = 1'b1;
    // R5 falling edge sets flag
    if (fall_irq_b)
      next_ctrl.ie1 = 1'b1;
    next_mode = mode;
    if (hit(dtu_pkg::IDX_MODE))
      next_mode = i_avs_writedata[7:0];
    events.tf0 = t0_ovf;
    events.tf1 = t1_ovf || t0_ovf_hi;
    events.ext0 = fall_irq_a;
    events.ext1 = fall_irq_b;
    next_stat = stat;
    if (hit(dtu_pkg::IDX_IRQ_CLR))
      next_stat = stat & ~i_avs_writedata[3:0];
    next_stat = next_stat | events;
    next_irq_en = irq_en;
    if (hit(dtu_pkg::IDX_IRQ_EN))
      next_irq_en = i_avs_writedata[3:0];
    next_irq = |(next_stat & next_irq_en);
    next_int_req.tf0 = next_ctrl.tf0;
    next_int_req.tf1 = next_ctrl.tf1;
    // R8 level or edge request
    next_int_req.ext0 = next_ctrl.it0 ? next_ctrl.ie0 : !i_ext_irq_pin_a;
    // R7 level or edge request
    next_int_req.ext1 = next_ctrl.it1 ? next_ctrl.ie1 : !i_ext_irq_pin_b;
    next_rdata = o_avs_readdata;
    if (rd)
    begin
      next_rdata = 32'h0000_0000;
      if (i_avs_address[1:0] != 2'h0)
        next_rdata[7:0] = dtu_pkg::RST_BYTE;
      else if (idx == dtu_pkg::IDX_CTRL)
        next_rdata[7:0] = ctrl;
      else if (idx == dtu_pkg::IDX_MODE)
        next_rdata[7:0] = mode;
      else if (idx == dtu_pkg::IDX_TL0)
        next_rdata[7:0] = t0_lo;
      else if (idx == dtu_pkg::IDX_TL1)
        next_rdata[7:0] = t1_lo;
      else if (idx == dtu_pkg::IDX_TH0)
        next_rdata[7:0] = t0_hi;
      else if (idx == dtu_pkg::IDX_TH1)
        next_rdata[7:0] = t1_hi;
      else if (idx == dtu_pkg::IDX_IRQ_STAT)
        next_rdata[3:0] = stat;
      else if (idx == dtu_pkg::IDX_IRQ_EN)
        next_rdata[3:0] = irq_en;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl <= dtu_pkg::RST_BYTE;
      mode <= dtu_pkg::RST_BYTE;
      stat <= dtu_pkg::RST_NIB;
      irq_en <= dtu_pkg::RST_NIB;
      o_int_req <= dtu_pkg::RST_NIB;
      o_irq <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
      ack <= 1'b0;
      half <= 1'b0;
      pins_q <= 4'h0;
    end
    else
    begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      stat <= next_stat;
      irq_en <= next_irq_en;
      o_int_req <= next_int_req;
      o_irq <= next_irq;
      o_avs_readdata <= next_rdata;
      ack <= o_avs_waitrequest;
      half <= !half;
      pins_q <= {i_count_input_b, i_count_input_a, i_ext_irq_pin_b,
                 i_ext_irq_pin_a};
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_fall_a;
    i_ext_irq_pin_a ##1 !i_ext_irq_pin_a;
  endsequence
  sequence s_fall_b;
    i_ext_irq_pin_b ##1 !i_ext_irq_pin_b;
  endsequence

  property p_tf1_set;
    (t1_ovf || t0_ovf_hi) |=> ctrl.tf1;
  endproperty
  a_tf1_set: assert property (p_tf1_set) else $error("tf1 not set"); // R1
  property p_tf0_clr;
    i_isr_ack.tf0 && !t0_ovf && !hit(dtu_pkg::IDX_CTRL) |=> !ctrl.tf0;
  endproperty
  a_tf0_clr: assert property (p_tf0_clr) else $error("tf0 not cleared"); // R2
  property p_t1_gate;
    mode.t1_gate && !i_ext_irq_pin_b && !hit(dtu_pkg::IDX_TL1)
      |=> $stable(t1_lo);
  endproperty
  a_t1_gate: assert property (p_t1_gate) else $error("t1 gated moved"); // R3
  property p_t0_stop;
    !ctrl.tr0 && mode.t0_mode != dtu_pkg::MODE_SPLIT &&
      !hit(dtu_pkg::IDX_TL0) && !hit(dtu_pkg::IDX_TH0)
      |=> $stable({t0_hi, t0_lo});
  endproperty
  a_t0_stop: assert property (p_t0_stop) else $error("t0 ran stopped"); // R4
  property p_ie1_fall;
    s_fall_b |=> ctrl.ie1;
  endproperty
  a_ie1_fall: assert property (p_ie1_fall) else $error("ie1 missed"); // R5
  property p_ie0_fall;
    s_fall_a |=> ctrl.ie0;
  endproperty
  a_ie0_fall: assert property (p_ie0_fall) else $error("ie0 missed"); // R6
  property p_lvl_b;
    !ctrl.it1 && !i_ext_irq_pin_b && !hit(dtu_pkg::IDX_CTRL)
      |=> o_int_req.ext1;
  endproperty
  a_lvl_b: assert property (p_lvl_b) else $error("level b lost"); // R7
  property p_half0;
    t0_inc && !mode.t0_count |=> !t0_inc;
  endproperty
  a_half0: assert property (p_half0) else $error("t0 too fast"); // R10
  property p_reload0;
    t0_inc && mode.t0_mode == dtu_pkg::MODE_RELOAD &&
      t0_lo == dtu_pkg::BYTE_MAX && !hit(dtu_pkg::IDX_TL0)
      |=> t0_lo == $past(t0_hi);
  endproperty
  a_reload0: assert property (p_reload0) else $error("no reload"); // R14
  property p_wrap;
    t0_ovf && mode.t0_mode == dtu_pkg::MODE_16 &&
      !hit(dtu_pkg::IDX_TL0) && !hit(dtu_pkg::IDX_TH0)
      |=> {t0_hi, t0_lo} == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // R16
endmodule
`default_nettype wire

// *** dv/dtu_pins.sv ***
// Pin-side model: pull-up pins pulsed or held low
`timescale 1ns/1ps
`default_nettype none
module dtu_pins
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Requests from bench
  input wire logic [3:0] i_fall,
  input wire logic [3:0] i_hold,
  // Pin levels
  output logic [3:0] o_pin
);
  logic [1:0] low_cnt [4];
  for (genvar k = 0; k < 4; k++)
  begin : g_pin
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
      if (!i_nrst)
        low_cnt[k] <= 2'h0;
      else if (i_fall[k])
        low_cnt[k] <= 2'h3;
      else if (low_cnt[k] != 2'h0)
        low_cnt[k] <= low_cnt[k] - 2'h1;
    end
    // Released pin returns to pull-up level
    assign o_pin[k] = !(i_hold[k] || low_cnt[k] != 2'h0);
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the dual timer and external interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [9:0] adr = 10'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic [3:0] fall = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [3:0] pin;
  dtu_pkg::dtu_vec_s ack = 4'h0;
  dtu_pkg::dtu_vec_s req;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic [7:0] q;
  int n;
  dtu_top i_dtu_top (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_ext_irq_pin_a(pin[0]), .i_ext_irq_pin_b(pin[1]),
    .i_count_input_a(pin[2]), .i_count_input_b(pin[3]),
    .i_isr_ack(ack), .o_int_req(req), .o_irq(irq));
  dtu_pins i_dtu_pins (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_fall(fall),
    .i_hold(hold), .o_pin(pin));
  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [7:0] got, input logic [7:0] lo,
    input logic [7:0] hi);
    samples_checked++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [7:0] r);
    int k;
    @(posedge i_mclk);
    adr <= {idx, 2'b00};
    rd_en <= !w;
    wr_en <= w;
    wdat <= {24'h000000, d};
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_mclk);
      if (wreq === 1'b0)
        break;
    end
    if (k == 50)
    begin
      failures++;
      end_sim();
    end
    r = rdat[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    bus(1'b0, idx, 8'h00, r);
  endtask
  task automatic pulse(input int k, input int c);
    repeat (c)
    begin
      @(posedge i_mclk);
      fall[k] <= 1'b1;
      @(posedge i_mclk);
      fall[k] <= 1'b0;
      cyc(6);
    end
  endtask
  task automatic pin_low(input int k, input logic lv);
    @(posedge i_mclk);
    hold[k] <= lv;
    cyc(4);
  endtask
  task automatic isr(input int b);
    @(posedge i_mclk);
    ack[b] <= 1'b1;
    @(posedge i_mclk);
    ack[b] <= 1'b0;
    cyc(2);
  endtask
  // Stop both timers, set modes, load timer t
  task automatic tset(input int t, input logic [7:0] m,
    input logic [7:0] hi, input logic [7:0] lo);
    wr(dtu_pkg::IDX_CTRL, 8'h00);
    wr(dtu_pkg::IDX_MODE, m);
    wr(dtu_pkg::IDX_TL0 + 8'(t), lo);
    wr(dtu_pkg::IDX_TH0 + 8'(t), hi);
  endtask
  function automatic logic [7:0] mf(input int t, input logic [3:0] nib);
    return t ? {nib, 4'h0} : {4'h0, nib};
  endfunction
  function automatic logic [7:0] tr(input int t);
    return t ? 8'h40 : 8'h10;
  endfunction
  function automatic int of(input int t);
    return t ? 7 : 5;
  endfunction
  initial
  begin
    n = $urandom(96);
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(dtu_pkg::IDX_CTRL + 8'(i), v);
      chk(v, 8'h00);
    end
    wr(8'hB0, 8'hFF);
    rd(8'hB0, v);
    chk(v, 8'h00);
    for (int t = 0; t < 2; t++)
    begin
      tset(t, mf(t, 4'h1), 8'hFF, 8'hF0);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      cyc(16);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b0);
      cyc(30);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b1);
      chk(req[2 * t], 1'b1);
      rd(dtu_pkg::IDX_TH0 + 8'(t), v);
      chk(v, 8'h00);
      isr(2 * t);
      chk(req[2 * t], 1'b0);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b0);
      n = $urandom_range(20, 100);
      q = 8'($urandom_range(0, 100));
      tset(t, mf(t, 4'h1), 8'h00, q);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      cyc(2 * n);
      wr(dtu_pkg::IDX_CTRL, 8'h00);
      rd(dtu_pkg::IDX_TL0 + 8'(t), v);
      chkr(v, q + 8'(n) - 8'h01, q + 8'(n) + 8'h03);
      // Gated timer waits for its pin
      tset(t, mf(t, 4'h9), 8'h00, 8'h00);
      pin_low(t, 1'b1);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      cyc(40);
      rd(dtu_pkg::IDX_TL0 + 8'(t), v);
      chk(v, 8'h00);
      pin_low(t, 1'b0);
      cyc(36);
      rd(dtu_pkg::IDX_TL0 + 8'(t), v);
      chkr(v, 8'h12, 8'h18);
      n = $urandom_range(1, 8);
      tset(t, mf(t, 4'h5), 8'h00, 8'h00);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      pulse(2 + t, n);
      rd(dtu_pkg::IDX_TL0 + 8'(t), v);
      chk(v, 8'(n));
      tset(t, mf(t, 4'h0), 8'hFE, 8'h00);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      cyc(100);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b0);
      cyc(40);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b1);
      tset(t, mf(t, 4'h2), 8'hF0, 8'hFE);
      wr(dtu_pkg::IDX_CTRL, tr(t));
      cyc(16);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[of(t)], 1'b1);
      wr(dtu_pkg::IDX_CTRL, 8'h00);
      rd(dtu_pkg::IDX_TL0 + 8'(t), v);
      chkr(v, 8'hF0, 8'hFF);
      rd(dtu_pkg::IDX_TH0 + 8'(t), v);
      chk(v, 8'hF0);
    end
    tset(1, 8'h30, 8'h00, 8'h00);
    wr(dtu_pkg::IDX_CTRL, 8'h40);
    cyc(20);
    rd(dtu_pkg::IDX_TL1, v);
    chk(v, 8'h00);
    tset(0, 8'h33, 8'hFF, 8'h00);
    wr(dtu_pkg::IDX_CTRL, 8'h40);
    cyc(20);
    rd(dtu_pkg::IDX_CTRL, v);
    chk(v[7], 1'b1);
    chk(v[5], 1'b0);
    rd(dtu_pkg::IDX_TL0, v);
    chk(v, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      wr(dtu_pkg::IDX_CTRL, 8'h01 << (2 * e));
      pulse(e, 1);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[1 + 2 * e], 1'b1);
      chk(req[1 + 2 * e], 1'b1);
      isr(1 + 2 * e);
      rd(dtu_pkg::IDX_CTRL, v);
      chk(v[1 + 2 * e], 1'b0);
      chk(req[1 + 2 * e], 1'b0);
      wr(dtu_pkg::IDX_CTRL, 8'h00);
      pin_low(e, 1'b1);
      chk(req[1 + 2 * e], 1'b1);
      pin_low(e, 1'b0);
      chk(req[1 + 2 * e], 1'b0);
    end
    // Status, enable and clear of the interrupt output
    tset(0, 8'h01, 8'hFF, 8'hFE);
    wr(dtu_pkg::IDX_IRQ_CLR, 8'h0F);
    wr(dtu_pkg::IDX_IRQ_EN, 8'h01);
    wr(dtu_pkg::IDX_CTRL, 8'h10);
    cyc(10);
    wr(dtu_pkg::IDX_CTRL, 8'h00);
    rd(dtu_pkg::IDX_IRQ_STAT, v);
    chk(v, 8'h01);
    chk(irq, 1'b1);
    wr(dtu_pkg::IDX_IRQ_STAT, 8'h00);
    rd(dtu_pkg::IDX_IRQ_STAT, v);
    chk(v, 8'h01);
    wr(dtu_pkg::IDX_IRQ_EN, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
    wr(dtu_pkg::IDX_IRQ_EN, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    wr(dtu_pkg::IDX_IRQ_CLR, 8'h01);
    cyc(2);
    chk(irq, 1'b0);
    rd(dtu_pkg::IDX_IRQ_STAT, v);
    chk(v, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
